/* bcbh_pkg.sv */
// Purpose: Constants and types for the backplane control block handler
// Assumes: 16-bit block words, APB register access, pclk at 40 MHz
// Notes: Block identifiers kept in hex, decimal value beside each
package bcbh_pkg;
  // Block identifiers
  localparam logic [15:0] ID_DISABLE = 16'h26AF; // 9903
  localparam logic [15:0] ID_STATUS = 16'h26DE; // 9950
  localparam logic [15:0] ID_WARM = 16'h270E; // 9998
  localparam logic [15:0] ID_COLD = 16'h270F; // 9999
  // Word positions in the incoming block
  localparam logic [5:0] W_ID = 6'h00;
  localparam logic [5:0] W_PORT = 6'h01;
  localparam logic [5:0] W_CNT = 6'h02;
  localparam logic [5:0] W_LIST = 6'h03;
  localparam logic [5:0] W_START = 6'h03;
  // Word positions in the response block
  localparam logic [5:0] R_ID = 6'h00;
  localparam logic [5:0] R_NEXT = 6'h01;
  localparam logic [5:0] R_PORT = 6'h02;
  localparam logic [5:0] R_CNT = 6'h03;
  localparam logic [5:0] R_START = 6'h04;
  localparam logic [5:0] R_ERR = 6'h05;
  // Limits
  localparam logic [15:0] DIS_MAX_CNT = 16'h003C; // 60
  localparam logic [15:0] STAT_MAX_CNT = 16'h0032; // 50
  localparam logic [15:0] MAX_PORT = 16'h0003;
  localparam logic [7:0] LIST_LAST = 8'h62; // 98, last index of 99
  localparam logic [2:0] ENA_CONT = 3'h4;
  localparam logic [2:0] ENA_ONCE = 3'h5;
  localparam logic [15:0] ENA_OFF = 16'h0000;
  // APB byte offsets
  localparam logic [11:0] A_WBLK = 12'h000;
  localparam logic [11:0] A_RBLK = 12'h100;
  localparam logic [11:0] A_CTRL = 12'h200;
  localparam logic [11:0] A_STATUS = 12'h204;
  localparam logic [11:0] A_NEXT = 12'h208;
  localparam logic [11:0] A_SEL = 12'h20C;
  localparam logic [11:0] A_CFG = 12'h210;
  localparam logic [11:0] A_ERR = 12'h214;
  localparam logic [11:0] A_MAXC = 12'h220;
  localparam logic [11:0] A_DB = 12'h400;
  // Reset values
  localparam logic [15:0] NEXT_ID_RST = 16'h0001;
  localparam logic [6:0] MAXC_RST = 7'h63; // 99 commands per port
  // Sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_DEC = 5'h02,
    S_DIS = 5'h04,
    S_STAT = 5'h08,
    S_END = 5'h10
  } bcbh_state_e;
  // Whole control state of the handler
  typedef struct packed {
    bcbh_state_e st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic resp_flag;
    logic rej_flag;
    logic [15:0] next_id;
    logic [3:0][6:0] maxc;
    logic [1:0] sel_port;
    logic [6:0] sel_idx;
    logic [1:0] op_port;
    logic [5:0] op_cnt;
    logic [6:0] op_start;
    logic [5:0] step;
    logic q_push;
    logic [1:0] q_port;
    logic [6:0] q_cmd;
    logic resume;
    logic warm;
    logic cold;
  } bcbh_state_s;
endpackage : bcbh_pkg

/* bcbh_handler.sv */
// Purpose: Interprets disable, status, warm and cold control blocks
// Assumes: Software loads the block image over APB, then writes go
// Notes: Command tables and enable words live in local arrays
// Notes on behaviour
// - Block 9903 zeroes the enable word of listed in-range code 4 and 5 commands
// - Disable touches only enable codes four and five
// - Port 0 to 3 selects its own list
// - Words 3..62 hold one-based command numbers
// - No disable response; selected commands are queued
// - Commands with undefined unit are not queued
// - Afterwards normal list execution resumes
// - Block 9950 requests one port's error table
// - Only valid status requests get a response
// - Response words: 9950, next id, port
// - Response word 3 holds reported count
// - Response word 4 holds first index
// - Words 5..54 hold last error codes
// - Block 9998 triggers a warm restart
// - Block 9999 triggers a cold restart
// - Enable code 5 one-shot, 4 continuous
`timescale 1ns/1ps
module bcbh_handler #(
  parameter int DB_DEPTH = 256,
  parameter int DB_AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic queue_push,
  output logic [1:0] queue_port,
  output logic [6:0] queue_cmd,
  output logic list_resume,
  output logic warm_restart,
  output logic cold_restart
);
  bcbh_pkg::bcbh_state_s s_reg;
  bcbh_pkg::bcbh_state_s s_next;
  bcbh_pkg::bcbh_state_s s_init;

  // Memories: block images, command tables, enable word database
  logic [15:0] wblk [0:63];
  logic [15:0] rblk [0:63];
  logic [2:0] cfg_code [0:511];
  logic cfg_unit [0:511];
  logic [7:0] cfg_loc [0:511];
  logic [15:0] cmd_err [0:511];
  logic [15:0] db [0:DB_DEPTH-1];

  logic acc;
  logic wr_done;
  logic go;
  logic [8:0] sel_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic rb_we;
  logic [5:0] rb_addr;
  logic [15:0] rb_data;
  logic db_fsm_we;
  logic [DB_AW-1:0] db_fsm_addr;
  logic [15:0] w_id;
  logic [15:0] w_port;
  logic [15:0] w_cnt;
  logic [15:0] w_start;
  logic [15:0] cur_cmd;
  logic [6:0] cur_idx;
  logic [8:0] cur_addr;
  logic [2:0] cur_code;
  logic [7:0] err_idx;
  logic [15:0] cur_err;
  logic [6:0] port_max;

  // Reset image, also used by a cold restart
  always_comb begin
    s_init = '0;
    s_init.st = bcbh_pkg::S_IDLE;
    s_init.next_id = bcbh_pkg::NEXT_ID_RST;
    for (int p = 0; p < 4; p++) begin
      s_init.maxc[p] = bcbh_pkg::MAXC_RST;
    end
  end

  // Bus decode: writes land on the completing edge only
  assign acc = psel & penable;
  assign wr_done = acc & s_reg.pready & pwrite;
  assign go = wr_done & (paddr == bcbh_pkg::A_CTRL) & pwdata[0];
  assign sel_addr = {s_reg.sel_port, s_reg.sel_idx};

  // Block word fields
  assign w_id = wblk[bcbh_pkg::W_ID];
  assign w_port = wblk[bcbh_pkg::W_PORT];
  assign w_cnt = wblk[bcbh_pkg::W_CNT];
  assign w_start = wblk[bcbh_pkg::W_START];
  assign port_max = s_reg.maxc[s_reg.op_port];

  // Current disable entry, numbers start at one
  assign cur_cmd = wblk[6'(bcbh_pkg::W_LIST + s_reg.step)];
  assign cur_idx = 7'(cur_cmd - 16'h0001);
  assign cur_addr = {s_reg.op_port, cur_idx};
  assign cur_code = cfg_code[cur_addr];

  // Error entry; past the list end reads zero, never a neighbour port
  assign err_idx = 8'({1'b0, s_reg.op_start} + {2'b00, s_reg.step}
                      - {2'b00, bcbh_pkg::R_ERR});
  assign cur_err = (err_idx > bcbh_pkg::LIST_LAST) ? 16'h0000 :
                   cmd_err[{s_reg.op_port, err_idx[6:0]}];

  // Register read mux, unmapped answers with slave error
  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (paddr[11:8] == bcbh_pkg::A_WBLK[11:8]) begin
      rd_data = {16'h0000, wblk[paddr[7:2]]};
    end else if (paddr[11:8] == bcbh_pkg::A_RBLK[11:8]) begin
      rd_data = {16'h0000, rblk[paddr[7:2]]};
    end else if (paddr[11:10] == bcbh_pkg::A_DB[11:10]) begin
      if (32'(paddr[9:2]) < DB_DEPTH) begin
        rd_data = {16'h0000, db[paddr[2+:DB_AW]]};
      end else begin
        rd_err = 1'b1;
      end
    end else begin
      unique case (paddr)
        bcbh_pkg::A_CTRL: rd_data = 32'h00000000;
        bcbh_pkg::A_STATUS: rd_data = {29'h0, s_reg.rej_flag,
          s_reg.resp_flag, (s_reg.st != bcbh_pkg::S_IDLE)};
        bcbh_pkg::A_NEXT: rd_data = {16'h0000, s_reg.next_id};
        bcbh_pkg::A_SEL: rd_data = {23'h0, sel_addr};
        bcbh_pkg::A_CFG: rd_data = {16'h0000, cfg_loc[sel_addr], 4'h0,
          cfg_unit[sel_addr], cfg_code[sel_addr]};
        bcbh_pkg::A_ERR: rd_data = {16'h0000, cmd_err[sel_addr]};
        bcbh_pkg::A_MAXC, bcbh_pkg::A_MAXC + 12'h004,
        bcbh_pkg::A_MAXC + 12'h008, bcbh_pkg::A_MAXC + 12'h00C:
          rd_data = {25'h0, s_reg.maxc[paddr[3:2]]};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Next state: bus handshake, registers and block sequencer
  always_comb begin
    s_next = s_reg;
    s_next.q_push = 1'b0;
    s_next.resume = 1'b0;
    s_next.warm = 1'b0;
    s_next.cold = 1'b0;
    rb_we = 1'b0;
    rb_addr = s_reg.step;
    rb_data = 16'h0000;
    db_fsm_we = 1'b0;
    db_fsm_addr = cfg_loc[cur_addr][DB_AW-1:0];
    // One wait state so read data comes from a flop
    s_next.pready = acc & ~s_reg.pready;
    if (acc & ~s_reg.pready) begin
      s_next.prdata = pwrite ? 32'h00000000 : rd_data;
      s_next.pslverr = rd_err;
    end
    // Register writes
    if (wr_done) begin
      if (paddr == bcbh_pkg::A_STATUS) begin
        if (pwdata[1]) s_next.resp_flag = 1'b0;
        if (pwdata[2]) s_next.rej_flag = 1'b0;
      end
      if (paddr == bcbh_pkg::A_NEXT) s_next.next_id = pwdata[15:0];
      if (paddr == bcbh_pkg::A_SEL) begin
        s_next.sel_port = pwdata[8:7];
        s_next.sel_idx = pwdata[6:0];
      end
      if (paddr[11:4] == bcbh_pkg::A_MAXC[11:4]) begin
        s_next.maxc[paddr[3:2]] = pwdata[6:0];
      end
    end
    // Block sequencer; set wins over a same-cycle clear
    unique case (s_reg.st)
      bcbh_pkg::S_IDLE: begin
        if (go) s_next.st = bcbh_pkg::S_DEC;
      end
      bcbh_pkg::S_DEC: begin
        s_next.st = bcbh_pkg::S_END;
        s_next.step = 6'h00;
        s_next.op_port = w_port[1:0];
        s_next.op_cnt = w_cnt[5:0];
        s_next.op_start = w_start[6:0];
        if (w_id == bcbh_pkg::ID_DISABLE) begin
          if (w_port <= bcbh_pkg::MAX_PORT && w_cnt != 16'h0000 &&
              w_cnt <= bcbh_pkg::DIS_MAX_CNT) begin
            s_next.st = bcbh_pkg::S_DIS;
          end else begin
            s_next.rej_flag = 1'b1;
          end
        end else if (w_id == bcbh_pkg::ID_STATUS) begin
          if (w_port <= bcbh_pkg::MAX_PORT && w_cnt != 16'h0000 &&
              w_cnt <= bcbh_pkg::STAT_MAX_CNT &&
              w_cnt <= {9'h000, s_reg.maxc[w_port[1:0]]} &&
              w_start < {9'h000, s_reg.maxc[w_port[1:0]]}) begin
            s_next.st = bcbh_pkg::S_STAT;
          end else begin
            s_next.rej_flag = 1'b1;
          end
        end else if (w_id == bcbh_pkg::ID_WARM) begin
          s_next.warm = 1'b1;
        end else if (w_id == bcbh_pkg::ID_COLD) begin
          s_next = s_init;
          s_next.cold = 1'b1;
        end
      end
      bcbh_pkg::S_DIS: begin
        // Out-of-list numbers are skipped quietly
        if (cur_cmd != 16'h0000 &&
            cur_cmd <= {9'h000, port_max} &&
            (cur_code == bcbh_pkg::ENA_CONT ||
             cur_code == bcbh_pkg::ENA_ONCE)) begin
          db_fsm_we = 1'b1;
          if (cfg_unit[cur_addr]) begin
            s_next.q_push = 1'b1;
            s_next.q_port = s_reg.op_port;
            s_next.q_cmd = cur_idx;
          end
        end
        s_next.step = 6'(s_reg.step + 6'h01);
        if (s_reg.step == 6'(s_reg.op_cnt - 6'h01)) begin
          s_next.resume = 1'b1;
          s_next.st = bcbh_pkg::S_END;
        end
      end
      bcbh_pkg::S_STAT: begin
        // Step doubles as response word position
        rb_we = 1'b1;
        if (s_reg.step == bcbh_pkg::R_ID) begin
          rb_data = bcbh_pkg::ID_STATUS;
        end else if (s_reg.step == bcbh_pkg::R_NEXT) begin
          rb_data = s_reg.next_id;
        end else if (s_reg.step == bcbh_pkg::R_PORT) begin
          rb_data = {14'h0000, s_reg.op_port};
        end else if (s_reg.step == bcbh_pkg::R_CNT) begin
          rb_data = {10'h000, s_reg.op_cnt};
        end else if (s_reg.step == bcbh_pkg::R_START) begin
          rb_data = {9'h000, s_reg.op_start};
        end else begin
          rb_data = cur_err;
        end
        s_next.step = 6'(s_reg.step + 6'h01);
        if (s_reg.step == 6'(bcbh_pkg::R_START + s_reg.op_cnt)) begin
          s_next.resp_flag = 1'b1;
          s_next.st = bcbh_pkg::S_END;
        end
      end
      bcbh_pkg::S_END: begin
        s_next.st = bcbh_pkg::S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= bcbh_pkg::S_IDLE;
      s_reg.next_id <= bcbh_pkg::NEXT_ID_RST;
      s_reg.maxc <= {4{bcbh_pkg::MAXC_RST}};
    end else begin
      s_reg <= s_next;
    end
  end

  // Block images and tables; not cleared by reset to keep them as RAM
  always_ff @(posedge pclk) begin
    if (wr_done && paddr[11:8] == bcbh_pkg::A_WBLK[11:8]) begin
      wblk[paddr[7:2]] <= pwdata[15:0];
    end
    if (wr_done && paddr == bcbh_pkg::A_CFG) begin
      cfg_code[sel_addr] <= pwdata[2:0];
      cfg_unit[sel_addr] <= pwdata[3];
      cfg_loc[sel_addr] <= pwdata[15:8];
    end
    if (wr_done && paddr == bcbh_pkg::A_ERR) begin
      cmd_err[sel_addr] <= pwdata[15:0];
    end
    if (rb_we) begin
      rblk[rb_addr] <= rb_data;
    end
  end

  // Enable words; the sequencer wins over a clashing bus write
  always_ff @(posedge pclk) begin
    if (db_fsm_we) begin
      db[db_fsm_addr] <= bcbh_pkg::ENA_OFF;
    end else if (wr_done && paddr[11:10] == bcbh_pkg::A_DB[11:10] &&
                 32'(paddr[9:2]) < DB_DEPTH) begin
      db[paddr[2+:DB_AW]] <= pwdata[15:0];
    end
  end

  // Outputs straight from the state flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign queue_push = s_reg.q_push;
  assign queue_port = s_reg.q_port;
  assign queue_cmd = s_reg.q_cmd;
  assign list_resume = s_reg.resume;
  assign warm_restart = s_reg.warm;
  assign cold_restart = s_reg.cold;
endmodule : bcbh_handler

/* bcbh_handler_properties.sv */
// Purpose: Port-level assertions for the control block handler
// Assumes: One clock domain, reset active low
// Notes: Attached to every handler instance by the bind below
`timescale 1ns/1ps
module bcbh_handler_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic queue_push,
  input wire logic [1:0] queue_port,
  input wire logic [6:0] queue_cmd,
  input wire logic list_resume,
  input wire logic warm_restart,
  input wire logic cold_restart
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Exactly one wait state after the first access cycle
  chk_ready_wait: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("ready latency wrong");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_req: assert property (pready |-> psel && penable)
    else $error("ready without request");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_warm_pulse: assert property (warm_restart |=> !warm_restart)
    else $error("warm pulse too long");
  chk_cold_pulse: assert property (cold_restart |=> !cold_restart)
    else $error("cold pulse too long");
  // Restarts never overlap each other or queue traffic
  chk_restart_alone: assert property (warm_restart || cold_restart |->
    !queue_push && !list_resume && !(warm_restart && cold_restart))
    else $error("restart overlaps other event");
  chk_cmd_range: assert property (queue_push |-> queue_cmd <= 7'h62)
    else $error("queued index out of list");
  // Cold restart clears the queue fields, as a power-up would
  chk_queue_held: assert property (!queue_push |->
    ($stable(queue_port) && $stable(queue_cmd)) ||
    (cold_restart && queue_port == 2'h0 && queue_cmd == 7'h00))
    else $error("queue fields moved without push");
  chk_resume_after: assert property (queue_push |-> ##[0:64] list_resume)
    else $error("no resume after disable");
  cover property (queue_push);
  cover property (list_resume);
  cover property (warm_restart);
  cover property (cold_restart);
  cover property (pslverr);
endmodule : bcbh_handler_properties
bind bcbh_handler bcbh_handler_properties u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .queue_push(queue_push), .queue_port(queue_port),
  .queue_cmd(queue_cmd), .list_resume(list_resume),
  .warm_restart(warm_restart), .cold_restart(cold_restart));

/* bcbh_plc_model.sv */
// Purpose: Processor side model, APB master writing control blocks
// Assumes: Caller enters tasks just after a rising edge
// Notes: Idle cycle between transfers keeps one assignment per step
`timescale 1ns/1ps
module bcbh_plc_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  int tmo = 0;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; request held until pready seen, bounded wait
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) tmo++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  // Block image words 0..3, then go; legal counts are up to caller
  task automatic blk(input logic [15:0] id, p, c, w3);
    logic [31:0] q;
    logic e;
    xfer(1'h1, 12'h000, {16'h0, id}, q, e);
    xfer(1'h1, 12'h004, {16'h0, p}, q, e);
    xfer(1'h1, 12'h008, {16'h0, c}, q, e);
    xfer(1'h1, 12'h00C, {16'h0, w3}, q, e);
    xfer(1'h1, bcbh_pkg::A_CTRL, 32'h1, q, e);
  endtask : blk
endmodule : bcbh_plc_model

/* bcbh_handler_tb_top.sv */
// Purpose: Self-checking bench for the control block handler
// Assumes: Error codes and command tables loaded over APB
// Notes: Row table first, then disable, restart and bus cases
`timescale 1ns/1ps
`define CHK(n,x,g) begin compares++; if ((g) !== (x)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", n, x, g); end end
module bcbh_handler_tb_top;
  typedef struct packed {
    logic [3:0] rej;
    logic [3:0] dis;
    logic [3:0] port;
    logic [7:0] cnt;
    logic [7:0] st;
  } bcbh_row_s;
  // Reject, disable, port, count, start; port 2 limited to ten
  bcbh_row_s rows [13] = '{28'h0_0_0_01_00, 28'h0_0_3_03_60,
    28'h0_0_1_32_00, 28'h1_0_1_00_00, 28'h1_0_0_33_00, 28'h1_0_4_01_00,
    28'h1_0_0_01_63, 28'h1_0_2_0B_00, 28'h0_0_2_01_09, 28'h1_0_2_01_0A,
    28'h1_1_4_01_00, 28'h1_1_0_00_00, 28'h1_1_0_3D_00};
  bcbh_row_s r;
  logic pclk = 1'h0, presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic queue_push, list_resume, warm_restart, cold_restart;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] queue_port, lp;
  logic [6:0] queue_cmd, lc;
  int compares = 0, miscompares = 0, k, m;
  int n_push = 0, n_res = 0, n_warm = 0, n_cold = 0;
  initial forever #12.5 pclk = ~pclk;
  bcbh_handler DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .queue_push(queue_push), .queue_port(queue_port),
    .queue_cmd(queue_cmd), .list_resume(list_resume),
    .warm_restart(warm_restart), .cold_restart(cold_restart));
  bcbh_plc_model P (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  // Event counters; last queued entry kept for checks
  always @(posedge pclk) begin
    if (queue_push === 1'h1) begin
      n_push++;
      lp = queue_port;
      lc = queue_cmd;
    end
    if (list_resume === 1'h1) n_res++;
    if (warm_restart === 1'h1) n_warm++;
    if (cold_restart === 1'h1) n_cold++;
  end
  // A stuck bus transfer ends the run at once
  always @(posedge pclk) begin
    if (P.tmo != 0) begin
      miscompares++;
      test_done;
    end
  end
  function automatic logic [15:0] err(input logic [3:0] p,
    input logic [7:0] i);
    return 16'hA000 | {4'h0, p, i};
  endfunction : err
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] t;
    logic x;
    P.xfer(1'h1, a, d, t, x);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic x;
    P.xfer(1'h0, a, 32'h0, d, x);
  endtask : rd
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && P.tmo == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Poll busy with a bound; STATUS left in s
  task automatic idle(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      rd(bcbh_pkg::A_STATUS, s);
      n++;
    end while (s[0] !== 1'h0 && n < 100);
    if (n >= 100) begin
      miscompares++;
      test_done;
    end
  endtask : idle
  initial begin
    #2500000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(bcbh_pkg::A_NEXT, q);
    `CHK("next rst", bcbh_pkg::NEXT_ID_RST, q[15:0])
    rd(bcbh_pkg::A_MAXC, q);
    `CHK("maxc rst", bcbh_pkg::MAXC_RST, q[6:0])
    wr(bcbh_pkg::A_NEXT, 32'h0123);
    wr(bcbh_pkg::A_MAXC + 12'h008, 32'h000A);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.dis == 4'h0 && r.rej == 4'h0)
        for (k = 0; k < r.cnt; k++) begin
          wr(bcbh_pkg::A_SEL, {r.port[1:0], 7'(r.st + k)});
          wr(bcbh_pkg::A_ERR, {16'h0, err(r.port, 8'(r.st + k))});
        end
      m = n_push;
      P.blk(r.dis[0] ? bcbh_pkg::ID_DISABLE : bcbh_pkg::ID_STATUS,
        16'(r.port), 16'(r.cnt), 16'(r.st));
      idle(q);
      `CHK("rejected", r.rej[0], q[2])
      `CHK("resp", ~r.rej[0] & ~r.dis[0], q[1])
      `CHK("no push", m, n_push)
      if (q[1] === 1'h1) begin
        rd(bcbh_pkg::A_RBLK, q);
        `CHK("w0", bcbh_pkg::ID_STATUS, q[15:0])
        rd(bcbh_pkg::A_RBLK + 12'h004, q);
        `CHK("w1", 16'h0123, q[15:0])
        rd(bcbh_pkg::A_RBLK + 12'h008, q);
        `CHK("w2", 16'(r.port), q[15:0])
        rd(bcbh_pkg::A_RBLK + 12'h00C, q);
        `CHK("w3", 16'(r.cnt), q[15:0])
        rd(bcbh_pkg::A_RBLK + 12'h010, q);
        `CHK("w4", 16'(r.st), q[15:0])
        for (k = 0; k < r.cnt; k++) begin
          rd(12'(bcbh_pkg::A_RBLK + 4 * (5 + k)), q);
          `CHK("err", err(r.port, 8'(r.st + k)), q[15:0])
        end
      end
      wr(bcbh_pkg::A_STATUS, 32'h6);
    end
    // Port 1: codes 4, 5 (unit missing), 3; port 0 shares slot 0
    wr(bcbh_pkg::A_SEL, 32'h80); wr(bcbh_pkg::A_CFG, 32'h050C);
    wr(bcbh_pkg::A_SEL, 32'h81); wr(bcbh_pkg::A_CFG, 32'h0605);
    wr(bcbh_pkg::A_SEL, 32'h82); wr(bcbh_pkg::A_CFG, 32'h070B);
    wr(bcbh_pkg::A_SEL, 32'h00); wr(bcbh_pkg::A_CFG, 32'h090C);
    rd(bcbh_pkg::A_CFG, q);
    `CHK("cfg rb", 16'h090C, q[15:0])
    for (k = 5; k < 10; k++) wr(12'(bcbh_pkg::A_DB + 4 * k), 32'hFFFF);
    wr(12'h010, 32'h2); wr(12'h014, 32'h3); wr(12'h018, 32'h0);
    m = n_push;
    P.blk(bcbh_pkg::ID_DISABLE, 16'h1, 16'h4, 16'h1);
    idle(q);
    `CHK("dis resp", 1'h0, q[1])
    `CHK("pushes", m + 1, n_push)
    `CHK("q port", 2'h1, lp)
    `CHK("q cmd", 7'h00, lc)
    `CHK("resume", 1, n_res)
    rd(bcbh_pkg::A_DB + 12'h014, q);
    `CHK("db5", 16'h0, q[15:0])
    rd(bcbh_pkg::A_DB + 12'h018, q);
    `CHK("db6", 16'h0, q[15:0])
    rd(bcbh_pkg::A_DB + 12'h01C, q);
    `CHK("db7", 16'hFFFF, q[15:0])
    rd(bcbh_pkg::A_DB + 12'h024, q);
    `CHK("db9", 16'hFFFF, q[15:0])
    P.blk(16'h1234, 16'h0, 16'h1, 16'h0);
    idle(q);
    `CHK("unknown", 3'h0, q[2:0] | {1'h0, 2'(n_warm + n_cold)})
    P.blk(bcbh_pkg::ID_WARM, 16'h0, 16'h0, 16'h0);
    idle(q);
    rd(bcbh_pkg::A_NEXT, q);
    `CHK("warm", 1, n_warm)
    `CHK("warm keep", 16'h0123, q[15:0])
    P.blk(bcbh_pkg::ID_COLD, 16'h0, 16'h0, 16'h0);
    idle(q);
    rd(bcbh_pkg::A_MAXC + 12'h008, q);
    `CHK("cold", 1, n_cold)
    `CHK("cold maxc", bcbh_pkg::MAXC_RST, q[6:0])
    P.xfer(1'h0, 12'h300, 32'h0, q, e);
    `CHK("unmapped", 33'h100000000, {e, q})
    test_done;
  end
endmodule : bcbh_handler_tb_top
